// *** core/pov_pkg.sv ***
package pov_pkg;

    // ****************************************************************
    // Command codes of the configuration registers.
    // ****************************************************************
    localparam logic [7:0] CMD_INPUT_TURN_OFF_LEVEL     = 8'h36;
    localparam logic [7:0] CMD_PHASE_SPREAD_SETUP       = 8'h37;
    localparam logic [7:0] CMD_CURRENT_READING_OFFSET   = 8'h39;
    localparam logic [7:0] CMD_OUTPUT_OVERVOLT_LIMIT    = 8'h40;
    localparam logic [7:0] CMD_OUTPUT_OVERVOLT_REACTION = 8'h41;

    // ****************************************************************
    // Reset values.
    // ****************************************************************
    localparam logic [15:0] RST_INPUT_TURN_OFF_LEVEL     = 16'h0000;
    localparam logic [15:0] RST_PHASE_SPREAD_SETUP       = 16'h0000;
    localparam logic [15:0] RST_CURRENT_READING_OFFSET   = 16'h0000;
    localparam logic [15:0] RST_OUTPUT_OVERVOLT_LIMIT    = 16'hFFFF;
    localparam logic [7:0]  RST_OUTPUT_OVERVOLT_REACTION = 8'h80;

    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int GROUP_ID_HI  = 11;
    localparam int GROUP_ID_LO  = 8;
    localparam int RAIL_CNT_HI  = 7;
    localparam int RAIL_CNT_LO  = 4;
    localparam int RAIL_POS_HI  = 3;
    localparam int RAIL_POS_LO  = 0;
    localparam int RESP_HI      = 7;
    localparam int RESP_LO      = 6;
    localparam int RETRY_HI     = 5;
    localparam int RETRY_LO     = 3;
    localparam int DELAY_HI     = 2;
    localparam int DELAY_LO     = 0;

    // Fixed exponent of the output voltage number format.
    localparam int VOUT_EXPONENT = -12;

    // ****************************************************************
    // Response modes and retry codes.
    // ****************************************************************
    localparam logic [1:0] RESP_IGNORE  = 2'h0;
    localparam logic [1:0] RESP_DELAYED = 2'h1;
    localparam logic [1:0] RESP_SHUTDN  = 2'h2;
    localparam logic [1:0] RESP_RESUME  = 2'h3;
    localparam logic [2:0] RETRY_NONE   = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // Length of one delay time unit, in ns, and its cycle count at 50 MHz.
    localparam int CLK_PERIOD_NS = 20;
    localparam int UNIT_NS       = 1000;
    localparam int UNIT_CYCLES   = (UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        POV_RUN     = 3'b000,
        POV_DELAY   = 3'b001,
        POV_OFF     = 3'b011,
        POV_WAIT    = 3'b010,
        POV_LATCHED = 3'b110
    } pov_state_t;

endpackage : pov_pkg

// *** core/pov_unit_timer.sv ***
// Counts out 2**exp_i delay units; done_o pulses one cycle at the end.
module pov_unit_timer #(
    parameter int UNIT_CYCLES = pov_pkg::UNIT_CYCLES
) (
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // Control.
    input  wire logic       start_i,
    input  wire logic [2:0] exp_i,
    output logic            busy_o,
    output logic            done_o
);
    logic [31:0] pre_r;
    logic [7:0]  units_r;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_r   <= 32'h0;
            units_r <= 8'h0;
            busy_o  <= 1'b0;
            done_o  <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                busy_o  <= 1'b1;
                pre_r   <= 32'h0;
                units_r <= 8'(1 << exp_i) - 8'h1; // R17
            end else if (busy_o) begin
                if (pre_r == 32'(UNIT_CYCLES - 1)) begin
                    pre_r <= 32'h0;
                    if (units_r == 8'h0) begin
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                    end else begin
                        units_r <= units_r - 8'h1;
                    end
                end else begin
                    pre_r <= pre_r + 32'h1;
                end
            end
        end
    end
endmodule : pov_unit_timer

// *** core/pov_cmd_regs.sv ***
// Holds the five command registers; the read data come out of a register.
module pov_cmd_regs (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // Command port.
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [7:0]  cmd_i,
    input  wire logic [15:0] wdata_i,
    output logic [15:0]      rdata_o,
    output logic             ack_o,
    output logic             err_o,
    // Register contents.
    output logic [15:0]      turn_off_o,
    output logic [15:0]      phase_o,
    output logic [15:0]      ioff_o,
    output logic [15:0]      ov_limit_o,
    output logic [7:0]       reaction_o
);
    logic hit;

    always_comb begin
        case (cmd_i)
            pov_pkg::CMD_INPUT_TURN_OFF_LEVEL,
            pov_pkg::CMD_PHASE_SPREAD_SETUP,
            pov_pkg::CMD_CURRENT_READING_OFFSET,
            pov_pkg::CMD_OUTPUT_OVERVOLT_LIMIT,
            pov_pkg::CMD_OUTPUT_OVERVOLT_REACTION: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            turn_off_o <= pov_pkg::RST_INPUT_TURN_OFF_LEVEL;
            phase_o    <= pov_pkg::RST_PHASE_SPREAD_SETUP;
            ioff_o     <= pov_pkg::RST_CURRENT_READING_OFFSET;
            ov_limit_o <= pov_pkg::RST_OUTPUT_OVERVOLT_LIMIT;
            reaction_o <= pov_pkg::RST_OUTPUT_OVERVOLT_REACTION;
        end else if (wr_i) begin
            case (cmd_i)
                pov_pkg::CMD_INPUT_TURN_OFF_LEVEL:     turn_off_o <= wdata_i; // R01
                pov_pkg::CMD_PHASE_SPREAD_SETUP:       phase_o    <= {4'h0, wdata_i[11:0]}; // R03
                pov_pkg::CMD_CURRENT_READING_OFFSET:   ioff_o     <= wdata_i;
                pov_pkg::CMD_OUTPUT_OVERVOLT_LIMIT:    ov_limit_o <= wdata_i; // R07
                pov_pkg::CMD_OUTPUT_OVERVOLT_REACTION: reaction_o <= wdata_i[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 16'h0;
            ack_o   <= 1'b0;
            err_o   <= 1'b0;
        end else begin
            ack_o <= (wr_i | rd_i) & hit;
            err_o <= (wr_i | rd_i) & ~hit;
            if (rd_i) begin
                case (cmd_i)
                    pov_pkg::CMD_INPUT_TURN_OFF_LEVEL:     rdata_o <= turn_off_o;
                    pov_pkg::CMD_PHASE_SPREAD_SETUP:       rdata_o <= phase_o;
                    pov_pkg::CMD_CURRENT_READING_OFFSET:   rdata_o <= ioff_o;
                    pov_pkg::CMD_OUTPUT_OVERVOLT_LIMIT:    rdata_o <= ov_limit_o;
                    pov_pkg::CMD_OUTPUT_OVERVOLT_REACTION: rdata_o <= {8'h0, reaction_o};
                    default:                               rdata_o <= 16'h0;
                endcase
            end
        end
    end
endmodule : pov_cmd_regs

// *** core/pov_ov_fault.sv ***
// Overview of operation
// R01: Hold input turn-off threshold; stop conversion once running when input reaches it.
// R02: Phase offset of switching is relative to the shared sync clock.
// R03: Bits 11:8 of phase setup hold the group identifier.
// R04: Bits 7:4 hold number of units in group, sync driver included.
// R05: Bits 3:0 hold interleave position; host gives sync driver position zero.
// R06: Add the current offset to every reported current reading.
// R07: Hold 16-bit over-voltage limit, unsigned, exponent -12.
// R08: Response 00 keeps operating through the fault.
// R09: Response 01 waits the delay, then applies retry field if fault persists.
// R10: Response 10 disables output at once, then follows retry field.
// R11: Response 11 disables only while fault present, resumes when it clears.
// R12: Retry 000 means no restart; output off until fault cleared.
// R13: Retry 001 to 100 allow one to four attempts, then latch off.
// R14: Retry 111 restarts without limit.
// R15: Restart interval equals delay count times the delay unit.
// R16: Retry 101 and 110 allow five and six attempts, then latch off.
// R17: Delay field is a power of two: 1 to 128 units.
// R18: Fault flagged when measured output exceeds the limit; response starts then.
// R19: Attempt counter resets on fault clear or successful restart.
module pov_ov_fault #(
    parameter int UNIT_CYCLES = pov_pkg::UNIT_CYCLES
) (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // Command port.
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [7:0]  cmd_i,
    input  wire logic [15:0] wdata_i,
    output logic [15:0]      rdata_o,
    output logic             ack_o,
    output logic             err_o,
    // Measurements and controls.
    input  wire logic [15:0] vout_meas_i,
    input  wire logic [15:0] vin_meas_i,
    input  wire logic [15:0] iout_raw_i,
    input  wire logic        clear_fault_i,
    input  wire logic        sync_i,
    // Outputs.
    output logic             output_en_o,
    output logic             ov_fault_o,
    output logic             latched_off_o,
    output logic             vin_off_o,
    output logic [15:0]      iout_report_o,
    output logic             phase_tick_o,
    output logic [3:0]       rail_group_identifier_o,
    output logic [3:0]       rail_count_o,
    output logic [3:0]       rail_position_o
);
    logic [15:0] turn_off;
    logic [15:0] phase;
    logic [15:0] ioff;
    logic [15:0] ov_limit;
    logic [7:0]  reaction;
    logic        tmr_start;
    logic        tmr_busy;
    logic        tmr_done;
    logic        fault;
    logic [1:0]  resp;
    logic [2:0]  retry;
    logic [2:0]  delay;
    logic [2:0]  tries_r;
    pov_pkg::pov_state_t state_r;
    pov_pkg::pov_state_t state_nxt;

    // ****************************************************************
    // Register bank and delay timer.
    // ****************************************************************
    pov_cmd_regs i_pov_cmd_regs (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .wr_i       (wr_i),
        .rd_i       (rd_i),
        .cmd_i      (cmd_i),
        .wdata_i    (wdata_i),
        .rdata_o    (rdata_o),
        .ack_o      (ack_o),
        .err_o      (err_o),
        .turn_off_o (turn_off),
        .phase_o    (phase),
        .ioff_o     (ioff),
        .ov_limit_o (ov_limit),
        .reaction_o (reaction)
    );

    pov_unit_timer #(.UNIT_CYCLES(UNIT_CYCLES)) i_pov_unit_timer (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .start_i (tmr_start),
        .exp_i   (delay),
        .busy_o  (tmr_busy),
        .done_o  (tmr_done)
    );

    assign resp  = reaction[pov_pkg::RESP_HI:pov_pkg::RESP_LO];
    assign retry = reaction[pov_pkg::RETRY_HI:pov_pkg::RETRY_LO];
    assign delay = reaction[pov_pkg::DELAY_HI:pov_pkg::DELAY_LO];
    assign fault = vout_meas_i > ov_limit; // R18

    // ****************************************************************
    // Fault response sequencer.
    // ****************************************************************
    always_comb begin
        state_nxt = state_r;
        tmr_start = 1'b0;
        case (state_r)
            pov_pkg::POV_RUN: begin
                if (fault) begin // R18
                    case (resp)
                        pov_pkg::RESP_IGNORE: state_nxt = pov_pkg::POV_RUN; // R08
                        pov_pkg::RESP_DELAYED: begin // R09
                            state_nxt = pov_pkg::POV_DELAY;
                            tmr_start = 1'b1;
                        end
                        pov_pkg::RESP_RESUME: state_nxt = pov_pkg::POV_OFF; // R11
                        default: begin // R10
                            state_nxt = (retry == pov_pkg::RETRY_NONE) ? pov_pkg::POV_LATCHED
                                                                       : pov_pkg::POV_WAIT; // R12
                            tmr_start = (retry != pov_pkg::RETRY_NONE);
                        end
                    endcase
                end
            end
            pov_pkg::POV_DELAY: begin
                if (!fault) begin
                    state_nxt = pov_pkg::POV_RUN;
                end else if (tmr_done) begin // R09
                    state_nxt = (retry == pov_pkg::RETRY_NONE) ? pov_pkg::POV_LATCHED
                                                               : pov_pkg::POV_WAIT;
                    tmr_start = (retry != pov_pkg::RETRY_NONE);
                end
            end
            pov_pkg::POV_OFF: begin
                if (!fault) begin
                    state_nxt = pov_pkg::POV_RUN; // R11
                end
            end
            pov_pkg::POV_WAIT: begin
                // Output off for one delay; then an attempt starts.
                if (tmr_done) begin
                    if (fault) begin
                        if (retry != pov_pkg::RETRY_FOREVER && tries_r >= retry) begin
                            state_nxt = pov_pkg::POV_LATCHED; // R13 R16
                        end else begin
                            tmr_start = 1'b1; // R14 R15
                        end
                    end else begin
                        state_nxt = pov_pkg::POV_RUN;
                    end
                end
            end
            pov_pkg::POV_LATCHED: begin
                if (clear_fault_i) begin
                    state_nxt = pov_pkg::POV_RUN; // R12
                end
            end
            default: state_nxt = pov_pkg::POV_RUN;
        endcase
        // A clear command leaves any retry or hold state.
        if (clear_fault_i && state_r != pov_pkg::POV_RUN) begin
            state_nxt = pov_pkg::POV_RUN;
            tmr_start = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= pov_pkg::POV_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tries_r <= 3'h0;
        end else if (clear_fault_i || state_nxt == pov_pkg::POV_RUN) begin
            tries_r <= 3'h0; // R19
        end else if (state_r == pov_pkg::POV_WAIT && tmr_done && fault && tries_r != 3'h7) begin
            tries_r <= tries_r + 3'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            output_en_o   <= 1'b1;
            ov_fault_o    <= 1'b0;
            latched_off_o <= 1'b0;
        end else begin
            output_en_o   <= (state_nxt == pov_pkg::POV_RUN) || (state_nxt == pov_pkg::POV_DELAY); // R10
            ov_fault_o    <= fault; // R18
            latched_off_o <= state_nxt == pov_pkg::POV_LATCHED;
        end
    end

    // ****************************************************************
    // Input turn-off, current offset and phase spreading.
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            vin_off_o     <= 1'b0;
            iout_report_o <= 16'h0;
        end else begin
            // Linear codes are compared as raw words; the caller keeps one exponent.
            vin_off_o     <= output_en_o && (vin_meas_i <= turn_off); // R01
            iout_report_o <= iout_raw_i + ioff; // R06
        end
    end

    logic [3:0] sync_cnt_r;
    logic       sync_d_r;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync_d_r                <= 1'b0;
            sync_cnt_r              <= 4'h0;
            phase_tick_o            <= 1'b0;
            rail_group_identifier_o <= 4'h0;
            rail_count_o            <= 4'h0;
            rail_position_o         <= 4'h0;
        end else begin
            sync_d_r                <= sync_i;
            rail_group_identifier_o <= phase[pov_pkg::GROUP_ID_HI:pov_pkg::GROUP_ID_LO]; // R03
            rail_count_o            <= phase[pov_pkg::RAIL_CNT_HI:pov_pkg::RAIL_CNT_LO]; // R04
            rail_position_o         <= phase[pov_pkg::RAIL_POS_HI:pov_pkg::RAIL_POS_LO]; // R05
            // Each rising sync edge advances a slot; this unit fires in its own slot. R02
            if (sync_i && !sync_d_r) begin
                sync_cnt_r <= (sync_cnt_r + 4'h1 >= rail_count_o) ? 4'h0 : sync_cnt_r + 4'h1;
            end
            phase_tick_o <= sync_i && !sync_d_r && (sync_cnt_r == rail_position_o); // R02
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    property p_ignore;
        @(posedge clk_i) disable iff (!rst_b_i)
        (state_r == pov_pkg::POV_RUN && resp == pov_pkg::RESP_IGNORE && !clear_fault_i) |=> output_en_o;
    endproperty
    a_ignore: assert property (p_ignore) else $error("output dropped in ignore mode"); // R08

    property p_shutdown;
        @(posedge clk_i) disable iff (!rst_b_i)
        (state_r == pov_pkg::POV_RUN && fault && resp == pov_pkg::RESP_SHUTDN) |=> !output_en_o;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown not immediate"); // R10

    property p_resume;
        @(posedge clk_i) disable iff (!rst_b_i)
        (state_r == pov_pkg::POV_OFF && !fault) |=> output_en_o;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume after fault cleared"); // R11

    property p_no_retry;
        @(posedge clk_i) disable iff (!rst_b_i)
        (state_r == pov_pkg::POV_RUN && fault && resp == pov_pkg::RESP_SHUTDN
         && retry == pov_pkg::RETRY_NONE && !clear_fault_i) |=> latched_off_o;
    endproperty
    a_no_retry: assert property (p_no_retry) else $error("retry zero did not latch"); // R12

    property p_latched_hold;
        @(posedge clk_i) disable iff (!rst_b_i)
        (latched_off_o && !clear_fault_i) |=> !output_en_o && latched_off_o;
    endproperty
    a_latched_hold: assert property (p_latched_hold) else $error("latched off left uncleared"); // R13

    property p_limit;
        @(posedge clk_i) disable iff (!rst_b_i)
        (state_r == pov_pkg::POV_WAIT && tmr_done && fault && retry != pov_pkg::RETRY_FOREVER
         && tries_r >= retry && !clear_fault_i) |=> latched_off_o;
    endproperty
    a_limit: assert property (p_limit) else $error("retry limit exceeded"); // R16

    property p_wait_timed;
        @(posedge clk_i) disable iff (!rst_b_i)
        (state_r == pov_pkg::POV_WAIT) |-> tmr_busy || tmr_done;
    endproperty
    a_wait_timed: assert property (p_wait_timed) else $error("retry wait without a running delay"); // R15

    property p_forever;
        @(posedge clk_i) disable iff (!rst_b_i)
        (retry == pov_pkg::RETRY_FOREVER && resp != pov_pkg::RESP_RESUME) |-> !latched_off_o || $past(retry) != retry;
    endproperty
    a_forever: assert property (p_forever) else $error("continuous retry latched off"); // R14

    property p_flag;
        @(posedge clk_i) disable iff (!rst_b_i)
        (vout_meas_i > ov_limit) |=> ov_fault_o;
    endproperty
    a_flag: assert property (p_flag) else $error("over-voltage not flagged"); // R18

    property p_tries_reset;
        @(posedge clk_i) disable iff (!rst_b_i)
        clear_fault_i |=> tries_r == 3'h0;
    endproperty
    a_tries_reset: assert property (p_tries_reset) else $error("attempt counter not reset"); // R19

    property p_offset;
        @(posedge clk_i) disable iff (!rst_b_i)
        1'b1 |=> iout_report_o == $past(iout_raw_i) + $past(ioff);
    endproperty
    a_offset: assert property (p_offset) else $error("current offset not applied"); // R06
endmodule : pov_ov_fault

// *** bench/pov_host_model.sv ***
// ****************************************************************
// Host side of the command port: one strobe per access.
// ****************************************************************
module pov_host_model (
    // Clock.
    input  wire logic        clk_i,
    // Command port towards the device.
    output logic             wr_o,
    output logic             rd_o,
    output logic [7:0]       cmd_o,
    output logic [15:0]      wdata_o,
    input  wire logic [15:0] rdata_i,
    input  wire logic        ack_i,
    input  wire logic        err_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        ack_q;
    logic        err_q;
    logic [15:0] rdata_q;
    initial begin
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        cmd_o   = 8'h00;
        wdata_o = 16'h0000;
    end
    // The strobe is held for exactly the edge that takes it, then the answer is sampled 1 ns after that same edge.
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
        @(posedge clk_i);
        wr_o    <= w;
        rd_o    <= !w;
        cmd_o   <= c;
        wdata_o <= d;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        #1;
        ack_q   = ack_i;
        err_q   = err_i;
        rdata_q = rdata_i;
    endtask : xfer
endmodule : pov_host_model

// *** bench/tb_pov_ov_fault.sv ***
module tb_pov_ov_fault;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_b_i, clear_fault_i, sync_i, wr, rd, ack, err, en, ovf, lat, voff, tick;
    logic [7:0]  cmd;
    logic [15:0] wd, rdat, vout, vin, iraw, irep;
    logic [3:0]  gid, cnt, pos;
    int          fail_count, samples_checked, n;
    logic [7:0]  cmds [5] = '{8'h36, 8'h37, 8'h39, 8'h40, 8'h41};
    logic [15:0] rsts [5] = '{pov_pkg::RST_INPUT_TURN_OFF_LEVEL, pov_pkg::RST_PHASE_SPREAD_SETUP,
                              pov_pkg::RST_CURRENT_READING_OFFSET, pov_pkg::RST_OUTPUT_OVERVOLT_LIMIT,
                              {8'h00, pov_pkg::RST_OUTPUT_OVERVOLT_REACTION}};
    // The short delay unit keeps the longest retry chain to a few dozen cycles.
    pov_ov_fault #(.UNIT_CYCLES(2)) i_pov_ov_fault (.clk_i(clk_i), .rst_b_i(rst_b_i), .wr_i(wr), .rd_i(rd),
        .cmd_i(cmd), .wdata_i(wd), .rdata_o(rdat), .ack_o(ack), .err_o(err), .vout_meas_i(vout),
        .vin_meas_i(vin), .iout_raw_i(iraw), .clear_fault_i(clear_fault_i), .sync_i(sync_i),
        .output_en_o(en), .ov_fault_o(ovf), .latched_off_o(lat), .vin_off_o(voff), .iout_report_o(irep),
        .phase_tick_o(tick), .rail_group_identifier_o(gid), .rail_count_o(cnt), .rail_position_o(pos));
    pov_host_model i_pov_host_model (.clk_i(clk_i), .wr_o(wr), .rd_o(rd), .cmd_o(cmd), .wdata_o(wd),
        .rdata_i(rdat), .ack_i(ack), .err_i(err));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        sync_i = 1'b0;
        forever begin
            repeat (9) @(posedge clk_i);
            sync_i <= ~sync_i;
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rng(input int got, input int lo, input int hi);
        chk(16'((got >= lo) && (got <= hi)), 16'h0001);
    endtask : rng
    task automatic wr_rd(input logic [7:0] c, input logic [15:0] d, input logic [15:0] exp);
        i_pov_host_model.xfer(1'b1, c, d);
        chk({15'h0000, i_pov_host_model.ack_q}, 16'h0001);
        i_pov_host_model.xfer(1'b0, c, 16'h0000);
        chk(i_pov_host_model.rdata_q, exp);
    endtask : wr_rd
    // Counts cycles until the selected output shows the wanted level, giving up after 300.
    task automatic wait_for(input int sel, output int cyc);
        cyc = 0;
        while (((sel == 0) ? lat !== 1'b1 : (sel == 1) ? en !== 1'b0 : en !== 1'b1) && cyc < 300) begin
            @(posedge clk_i);
            #1;
            cyc++;
        end
    endtask : wait_for
    task automatic clear;
        @(posedge clk_i);
        vout          <= 16'h0800;
        clear_fault_i <= 1'b1;
        @(posedge clk_i);
        clear_fault_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : clear
    task automatic fault(input logic [7:0] reaction, input int sel, output int cyc);
        i_pov_host_model.xfer(1'b1, 8'h41, {8'h00, reaction});
        @(posedge clk_i);
        vout <= 16'h2000;
        @(posedge clk_i);
        #1;
        wait_for(sel, cyc);
    endtask : fault
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #200000;
        fail_count++;
        end_of_test();
    end
    initial begin
        fail_count = 0;
        samples_checked = 0;
        rst_b_i = 1'b0;
        clear_fault_i = 1'b0;
        vout = 16'h0800;
        vin = 16'hC000;
        iraw = 16'h1234;
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            i_pov_host_model.xfer(1'b0, cmds[i], 16'h0000);
            chk(i_pov_host_model.rdata_q, rsts[i]);
        end
        i_pov_host_model.xfer(1'b0, 8'h38, 16'h0000);
        chk({15'h0000, i_pov_host_model.err_q}, 16'h0001);
        $display("test reset values done");
        wr_rd(8'h36, 16'hB000, 16'hB000);
        wr_rd(8'h37, 16'hF5A0, 16'h05A0);
        chk({4'h0, gid, cnt, pos}, 16'h05A0);
        wr_rd(8'h39, 16'hF00F, 16'hF00F);
        chk(irep, 16'h0243);
        wr_rd(8'h40, 16'h1000, 16'h1000);
        chk({15'h0000, voff}, 16'h0000);
        @(posedge clk_i);
        vin <= 16'hB000;
        repeat (3) @(posedge clk_i);
        chk({15'h0000, voff}, 16'h0001);
        vin <= 16'hC000;
        $display("test registers done");
        fault(8'h00, 0, n);
        chk({14'h0000, ovf, en}, 16'h0003);
        clear();
        fault(8'h80, 0, n);
        rng(n, 0, 3);
        chk({15'h0000, en}, 16'h0000);
        clear();
        chk({15'h0000, en}, 16'h0001);
        fault(8'hC0, 1, n);
        rng(n, 0, 2);
        @(posedge clk_i);
        vout <= 16'h0800;
        wait_for(2, n);
        rng(n, 1, 3);
        chk({15'h0000, lat}, 16'h0000);
        clear();
        fault(8'h42, 1, n);
        rng(n, 7, 14);
        clear();
        fault(8'h51, 0, n);
        rng(n, 19, 22);
        clear();
        for (int r = 1; r < 7; r++) begin
            fault({2'b10, 3'(r), 3'h1}, 0, n);
            rng(n, (r + 1) * 5 - 1, (r + 1) * 5 + 2);
            clear();
        end
        fault(8'hB9, 0, n);
        chk({15'h0000, lat}, 16'h0000);
        clear();
        $display("test fault responses done");
        wr_rd(8'h37, 16'h0021, 16'h0021);
        repeat (36) @(posedge clk_i);
        n = 0;
        repeat (72) begin
            @(posedge clk_i);
            #1;
            n += int'(tick);
        end
        chk(16'(n), 16'h0002);
        $display("test phase spreading done");
        end_of_test();
    end
endmodule : tb_pov_ov_fault
